// *** hdl/scl_count_pkg.sv ***
// Constants shared by the SCL period count block and its idle detector
package scl_count_pkg;

    // Register byte addresses
    localparam logic [31:0] STD_SCL_HIGH_COUNT_ADDR  = 32'h5000_1314;
    localparam logic [31:0] STD_SCL_LOW_COUNT_ADDR   = 32'h5000_1318;
    localparam logic [31:0] FAST_SCL_HIGH_COUNT_ADDR = 32'h5000_131C;
    localparam logic [31:0] FAST_SCL_LOW_COUNT_ADDR  = 32'h5000_1320;

    // Register indices inside the block
    localparam int          NUM_COUNTS = 4;
    localparam logic [1:0]  IDX_STD_HIGH  = 2'h0;
    localparam logic [1:0]  IDX_STD_LOW   = 2'h1;
    localparam logic [1:0]  IDX_FAST_HIGH = 2'h2;
    localparam logic [1:0]  IDX_FAST_LOW  = 2'h3;

    // Field layout
    localparam int          COUNT_W  = 16;
    localparam int          LO_BYTE_LSB = 0;
    localparam int          HI_BYTE_LSB = 8;

    // Reset values
    localparam logic [15:0] STD_HIGH_RESET  = 16'h0048;
    localparam logic [15:0] STD_LOW_RESET   = 16'h004F;
    localparam logic [15:0] FAST_HIGH_RESET = 16'h0008;
    localparam logic [15:0] FAST_LOW_RESET  = 16'h0017;

    // Hardware floors of the written values
    localparam logic [15:0] HIGH_COUNT_MIN = 16'h0006;
    localparam logic [15:0] LOW_COUNT_MIN  = 16'h0008;

    // Idle threshold margin above the standard high count
    localparam logic [16:0] IDLE_MARGIN = 17'h0000A;

    // Speed selection codes from the controller
    typedef enum logic [1:0] {
        SPEED_NONE = 2'h0,
        SPEED_STD  = 2'h1,
        SPEED_FAST = 2'h2,
        SPEED_HIGH = 2'h3
    } speed_t;

endpackage

// *** hdl/bus_idle_detect.sv ***
// Bus idle detector: counts cycles with SCL and SDA both high
`timescale 1ns/100ps
`default_nettype none

module bus_idle_detect (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // Bus pins, asynchronous to clk_in
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // Threshold base from the standard high count
    input  wire logic [15:0] std_high_in,
    // Idle flag
    output logic             bus_idle_out
);

    typedef struct packed {
        logic [1:0]  scl_sync;
        logic [1:0]  sda_sync;
        logic [15:0] idle_cnt;
        logic        idle;
    } idle_state_t;

    idle_state_t state_ff;
    idle_state_t nxt_state;
    logic [16:0] threshold;

    // Wide sum keeps an oversized high count from wrapping the threshold
    assign threshold = {1'b0, std_high_in} + scl_count_pkg::IDLE_MARGIN;

    // Two-stage synchronisers, then counting on the second stage only
    always_comb begin
        nxt_state          = state_ff;
        nxt_state.scl_sync = {state_ff.scl_sync[0], scl_in};
        nxt_state.sda_sync = {state_ff.sda_sync[0], sda_in};
        if (!(state_ff.scl_sync[1] && state_ff.sda_sync[1])) begin
            nxt_state.idle_cnt = 16'h0000;
            nxt_state.idle     = 1'b0;
        end else begin
            if (state_ff.idle_cnt != 16'hFFFF) begin // Saturate
                nxt_state.idle_cnt = state_ff.idle_cnt + 16'h0001;
            end
            if ({1'b0, state_ff.idle_cnt} >= threshold) begin
                nxt_state.idle = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign bus_idle_out = state_ff.idle;

endmodule

`default_nettype wire

// *** hdl/scl_period_counts.sv ***
// SCL period count registers with APB access and speed-based selection
`timescale 1ns/100ps
`default_nettype none

// How it works
// - A 16-bit standard-speed SCL high count resets to 0x48.
// - A 16-bit standard-speed SCL low count resets to 0x4F.
// - A 16-bit fast-speed SCL high count resets to 0x8.
// - A 16-bit fast-speed SCL low count resets to 0x17.
// - In high-speed mode the preamble is timed with the fast counts.
// - Writes to any count take effect only while the controller is off.
// - A high count written below 6 is stored as 6.
// - A low count written below 8 is stored as 8.
// - Bus idle is flagged when the idle counter reaches std high plus 10.
module scl_period_counts (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    // APB register port
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [31:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    input  wire logic [3:0]  pstrb_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Controller state
    input  wire logic        controller_on_in,
    input  wire logic [1:0]  speed_sel_in,
    input  wire logic        hs_preamble_in,
    // Bus pins for idle detection
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    // Counts for the SCL period counters, HS select and bus idle flag
    output logic [15:0]      scl_high_count_out,
    output logic [15:0]      scl_low_count_out,
    output logic             use_hs_counts_out,
    output logic             bus_idle_out
);

    typedef struct packed {
        logic [scl_count_pkg::NUM_COUNTS-1:0][15:0] counts;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
        logic [15:0] sel_high;
        logic [15:0] sel_low;
        logic        use_hs;
    } regs_state_t;

    regs_state_t state_ff;
    regs_state_t nxt_state;
    logic [2:0]  rd_hit;
    logic [2:0]  wr_hit;
    logic        setup_phase;
    logic        access_phase;

    // Address decode: bit 2 flags a hit, bits 1:0 give the index
    function automatic logic [2:0] decode(input logic [31:0] addr);
        logic [2:0] hit;
        hit = 3'h0;
        unique case (addr)
            scl_count_pkg::STD_SCL_HIGH_COUNT_ADDR:
                hit = {1'b1, scl_count_pkg::IDX_STD_HIGH};
            scl_count_pkg::STD_SCL_LOW_COUNT_ADDR:
                hit = {1'b1, scl_count_pkg::IDX_STD_LOW};
            scl_count_pkg::FAST_SCL_HIGH_COUNT_ADDR:
                hit = {1'b1, scl_count_pkg::IDX_FAST_HIGH};
            scl_count_pkg::FAST_SCL_LOW_COUNT_ADDR:
                hit = {1'b1, scl_count_pkg::IDX_FAST_LOW};
            default:
                hit = 3'h0;
        endcase
        return hit;
    endfunction

    // Floor applied to the merged 16-bit value, not per byte lane
    function automatic logic [15:0] floor_to(input logic [15:0] value,
                                             input logic [15:0] minimum);
        return (value < minimum) ? minimum : value;
    endfunction

    assign setup_phase  = psel_in && !penable_in;
    assign access_phase = psel_in && penable_in;
    assign rd_hit       = decode(paddr_in);
    assign wr_hit       = decode(paddr_in);

    // Register writes, read data capture and count selection
    always_comb begin
        logic [15:0] merged;
        merged    = 16'h0000;
        nxt_state = state_ff;

        // Zero-wait APB: ready and error are set up for the access phase
        nxt_state.ready  = setup_phase;
        nxt_state.slverr = setup_phase && !rd_hit[2];
        if (setup_phase) begin
            nxt_state.rdata = 32'h0000_0000;
            if (rd_hit[2] && !pwrite_in) begin
                nxt_state.rdata = {16'h0000, state_ff.counts[rd_hit[1:0]]};
            end
        end

        // Writes land only while the controller is off
        if (access_phase && pwrite_in && wr_hit[2]
            && !controller_on_in) begin
            merged = state_ff.counts[wr_hit[1:0]];
            // Byte lanes allow a low-then-high pair on a narrow bus
            if (pstrb_in[0]) begin
                merged[scl_count_pkg::LO_BYTE_LSB +: 8] =
                    pwdata_in[scl_count_pkg::LO_BYTE_LSB +: 8];
            end
            if (pstrb_in[1]) begin
                merged[scl_count_pkg::HI_BYTE_LSB +: 8] =
                    pwdata_in[scl_count_pkg::HI_BYTE_LSB +: 8];
            end
            if (wr_hit[0] == 1'b0) begin
                nxt_state.counts[wr_hit[1:0]] =
                    floor_to(merged, scl_count_pkg::HIGH_COUNT_MIN);
            end else begin
                nxt_state.counts[wr_hit[1:0]] =
                    floor_to(merged, scl_count_pkg::LOW_COUNT_MIN);
            end
        end

        // Pair selection for the SCL period counters
        nxt_state.use_hs = 1'b0;
        unique case (scl_count_pkg::speed_t'(speed_sel_in))
            scl_count_pkg::SPEED_FAST: begin
                nxt_state.sel_high =
                    state_ff.counts[scl_count_pkg::IDX_FAST_HIGH];
                nxt_state.sel_low  =
                    state_ff.counts[scl_count_pkg::IDX_FAST_LOW];
            end
            scl_count_pkg::SPEED_HIGH: begin
                // Preamble runs at fast timing; data phase uses HS counts
                nxt_state.sel_high =
                    state_ff.counts[scl_count_pkg::IDX_FAST_HIGH];
                nxt_state.sel_low  =
                    state_ff.counts[scl_count_pkg::IDX_FAST_LOW];
                nxt_state.use_hs   = !hs_preamble_in;
            end
            scl_count_pkg::SPEED_STD,
            scl_count_pkg::SPEED_NONE: begin
                // Unused code falls back to the safe slow timing
                nxt_state.sel_high =
                    state_ff.counts[scl_count_pkg::IDX_STD_HIGH];
                nxt_state.sel_low  =
                    state_ff.counts[scl_count_pkg::IDX_STD_LOW];
            end
        endcase
    end

    // State register with documented reset counts
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_ff <= '0;
            state_ff.counts[scl_count_pkg::IDX_STD_HIGH] <=
                scl_count_pkg::STD_HIGH_RESET;
            state_ff.counts[scl_count_pkg::IDX_STD_LOW] <=
                scl_count_pkg::STD_LOW_RESET;
            state_ff.counts[scl_count_pkg::IDX_FAST_HIGH] <=
                scl_count_pkg::FAST_HIGH_RESET;
            state_ff.counts[scl_count_pkg::IDX_FAST_LOW] <=
                scl_count_pkg::FAST_LOW_RESET;
            state_ff.sel_high <= scl_count_pkg::STD_HIGH_RESET;
            state_ff.sel_low  <= scl_count_pkg::STD_LOW_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Idle detection keyed to the standard high count
    bus_idle_detect idle_detect (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .scl_in       (scl_in),
        .sda_in       (sda_in),
        .std_high_in  (state_ff.counts[scl_count_pkg::IDX_STD_HIGH]),
        .bus_idle_out (bus_idle_out)
    );

    assign prdata_out         = state_ff.rdata;
    assign pready_out         = state_ff.ready;
    assign pslverr_out        = state_ff.slverr;
    assign scl_high_count_out = state_ff.sel_high;
    assign scl_low_count_out  = state_ff.sel_low;
    assign use_hs_counts_out  = state_ff.use_hs;

endmodule

`default_nettype wire

// *** verif/i2c_bus_model.sv ***
// Far-side I2C bus stand-in: two lines with pull-ups
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_model (
    // Control from the bench
    input  wire logic busy_in,
    // Bus lines
    output logic      scl_out,
    output logic      sda_out
);
    // Released lines rest at the pull-up level; busy holds data low
    assign scl_out = 1'h1;
    assign sda_out = ~busy_in;
endmodule
`default_nettype wire

// *** verif/scl_period_counts_sva.sv ***
// Port assertions for the SCL period count block
`timescale 1ns/100ps
`default_nettype none
module scl_period_counts_sva (
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        controller_on_in,
    input wire logic [1:0]  speed_sel_in,
    input wire logic        hs_preamble_in,
    input wire logic        sda_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [15:0] scl_high_count_out,
    input wire logic [15:0] scl_low_count_out,
    input wire logic        use_hs_counts_out,
    input wire logic        bus_idle_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Bus phases and a locked controller window
    sequence setup_s;
        psel_in && !penable_in;
    endsequence
    sequence locked_s;
        (controller_on_in && $stable(speed_sel_in))[*3];
    endsequence
    // Each check ties an output to its cause
    a_ready_one_cycle: assert property (setup_s |=> pready_out ##1 !pready_out)
        else $error("ready pulse wrong after setup");
    a_ready_from_setup: assert property (pready_out |-> $past(psel_in))
        else $error("ready without a setup phase");
    a_err_with_ready: assert property (pslverr_out |-> pready_out)
        else $error("error shown without ready");
    a_count_floor: assert property (scl_high_count_out >= 16'h0006 &&
        scl_low_count_out >= 16'h0008) else $error("count below floor");
    a_preamble_fast: assert property ((speed_sel_in == 2'h3) &&
        hs_preamble_in |=> !use_hs_counts_out) else $error("hs during preamble");
    a_hs_after_pre: assert property ((speed_sel_in == 2'h3) &&
        !hs_preamble_in |=> use_hs_counts_out) else $error("hs not selected");
    a_std_no_hs: assert property (speed_sel_in != 2'h3 |=>
        !use_hs_counts_out) else $error("hs outside high speed");
    a_locked_counts: assert property (locked_s |=>
        $stable(scl_high_count_out) && $stable(scl_low_count_out))
        else $error("count moved while enabled");
    a_idle_drops: assert property (!sda_in |-> ##[1:6] !bus_idle_out)
        else $error("idle flag stuck after data low");
endmodule
bind scl_period_counts scl_period_counts_sva scl_period_counts_sva_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .controller_on_in(controller_on_in),
    .speed_sel_in(speed_sel_in), .hs_preamble_in(hs_preamble_in),
    .sda_in(sda_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .scl_high_count_out(scl_high_count_out),
    .scl_low_count_out(scl_low_count_out),
    .use_hs_counts_out(use_hs_counts_out), .bus_idle_out(bus_idle_out));
`default_nettype wire

// *** verif/scl_period_counts_bench.sv ***
// Self-checking bench for the SCL period count block
`timescale 1ns/100ps
`default_nettype none
module scl_period_counts_bench;
    logic        clk_in = 1'h0;
    logic        rst_n_in = 1'h0;
    logic        psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic        on = 1'h0, pre = 1'h0, busy = 1'h1;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [3:0]  pstrb = 4'h0;
    logic [1:0]  spd = 2'h1;
    logic        prdy, perr, use_hs, idle, scl, sda, er;
    logic [15:0] hi_cnt, lo_cnt;
    logic [31:0] adr [4] = '{scl_count_pkg::STD_SCL_HIGH_COUNT_ADDR,
        scl_count_pkg::STD_SCL_LOW_COUNT_ADDR,
        scl_count_pkg::FAST_SCL_HIGH_COUNT_ADDR,
        scl_count_pkg::FAST_SCL_LOW_COUNT_ADDR};
    logic [15:0] rst [4] = '{16'h0048, 16'h004F, 16'h0008, 16'h0017};
    logic [15:0] mn [4] = '{16'h0006, 16'h0008, 16'h0006, 16'h0008};
    int          error_cnt = 0, n_checks = 0, cyc = 0, n;

    scl_period_counts scl_period_counts_i (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
        .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(prdy),
        .pslverr_out(perr), .controller_on_in(on), .speed_sel_in(spd),
        .hs_preamble_in(pre), .scl_in(scl), .sda_in(sda),
        .scl_high_count_out(hi_cnt), .scl_low_count_out(lo_cnt),
        .use_hs_counts_out(use_hs), .bus_idle_out(idle));
    i2c_bus_model i2c_bus_model_i (.busy_in(busy), .scl_out(scl),
        .sda_out(sda));

    // Clock and hang guard; whole run is well under a thousand cycles
    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One zero-wait transfer, then an idle cycle so strobes never retoggle
    task automatic apb(input logic w, input logic [31:0] a,
                       input logic [15:0] d, input logic [3:0] s);
        psel <= 1'h1;
        pwr <= w;
        paddr <= a;
        pwdata <= {16'h0, d};
        pstrb <= s;
        @(posedge clk_in);
        pen <= 1'h1;
        @(posedge clk_in);
        rd = prdata;
        er = perr;
        chk("ready", 32'h1, {31'h0, prdy});
        psel <= 1'h0;
        pen <= 1'h0;
        @(posedge clk_in);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [15:0] e);
        apb(1'h0, a, 16'h0, 4'h0);
        chk("read data", {16'h0, e}, rd);
    endtask

    // Speed selection, settled after the output register
    task automatic sel(input logic [1:0] s, input logic p,
                       input logic [15:0] h, input logic [15:0] l,
                       input logic u);
        spd <= s;
        pre <= p;
        repeat (3) @(posedge clk_in);
        chk("selected pair", {h, l}, {hi_cnt, lo_cnt});
        chk("hs select", {31'h0, u}, {31'h0, use_hs});
    endtask

    task automatic final_report();
        if (error_cnt == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence: reset values, floors, lanes, lock, map, select, idle
    initial begin
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'h1;
        @(posedge clk_in);
        for (int i = 0; i < 4; i++) begin
            rdchk(adr[i], rst[i]);
        end
        chk("std pair", 32'h0048004F, {hi_cnt, lo_cnt});
        for (int i = 0; i < 4; i++) begin
            apb(1'h1, adr[i], mn[i] - 16'h1, 4'h3);
            chk("write rdata", 32'h0, rd);
            rdchk(adr[i], mn[i]);
            apb(1'h1, adr[i], 16'h12A5, 4'h1);
            apb(1'h1, adr[i], {8'h34 + 8'(i), 8'h00}, 4'h2);
            rdchk(adr[i], {8'h34 + 8'(i), 8'hA5});
            on <= 1'h1;
            apb(1'h1, adr[i], 16'h0BCD, 4'h3);
            rdchk(adr[i], {8'h34 + 8'(i), 8'hA5});
            on <= 1'h0;
        end
        apb(1'h0, 32'h5000_1324, 16'h0, 4'h0);
        chk("unmapped", 32'h1, {rd[30:0], er});
        sel(2'h1, 1'h0, 16'h34A5, 16'h35A5, 1'h0);
        sel(2'h2, 1'h0, 16'h36A5, 16'h37A5, 1'h0);
        sel(2'h3, 1'h1, 16'h36A5, 16'h37A5, 1'h0);
        sel(2'h3, 1'h0, 16'h36A5, 16'h37A5, 1'h1);
        sel(2'h0, 1'h0, 16'h34A5, 16'h35A5, 1'h0);
        spd <= 2'h1;
        apb(1'h1, adr[0], 16'h0000, 4'h3);
        // Threshold is now floor 6 plus 10 cycles of both lines high
        busy <= 1'h0;
        n = 0;
        while (idle !== 1'h1 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        chk("idle delay", 32'h1, {31'h0, n >= 16 && n <= 20});
        busy <= 1'h1;
        repeat (6) @(posedge clk_in);
        chk("idle clear", 32'h0, {31'h0, idle});
        final_report();
    end
endmodule
`default_nettype wire
